// file: common/ars_pkg.sv
// Constants and types shared by the auto-reclose sequencer.
`default_nettype none
package ars_pkg;
    // Timer tick period and system clock period, in nanoseconds.
    localparam int ARS_TICK_NS = 32'h000F_4240;
    localparam int ARS_CLK_NS = 32'h0000_000A;
    localparam int ARS_TICK_CYCLES = ARS_TICK_NS / ARS_CLK_NS;
    // Register byte offsets.
    localparam logic [7:0] ARS_OFF_CTRL = 8'h00;
    localparam logic [7:0] ARS_OFF_DEAD_GND = 8'h04;
    localparam logic [7:0] ARS_OFF_DEAD_PH = 8'h08;
    localparam logic [7:0] ARS_OFF_RESTRAIN = 8'h0C;
    localparam logic [7:0] ARS_OFF_CLOSE_MAX = 8'h10;
    localparam logic [7:0] ARS_OFF_ACTION = 8'h14;
    localparam logic [7:0] ARS_OFF_HOLD_MAX = 8'h18;
    localparam logic [7:0] ARS_OFF_LOCKOUT = 8'h1C;
    localparam logic [7:0] ARS_OFF_STATUS = 8'h20;
    // Control field positions.
    localparam int ARS_CTRL_AUX_BIT = 32'h0000_0000;
    localparam int ARS_CTRL_GCNT_LSB = 32'h0000_0004;
    localparam int ARS_CTRL_PCNT_LSB = 32'h0000_0008;
    // Largest number of attempts per program.
    localparam logic [3:0] ARS_MAX_SHOTS = 4'h9;
    // Reset values.
    localparam logic [3:0] ARS_RST_GCNT = 4'h1;
    localparam logic [3:0] ARS_RST_PCNT = 4'h1;
    localparam logic ARS_RST_AUX = 1'h1;
    localparam logic [31:0] ARS_RST_DEAD = 32'h0A0A_0A0A;
    localparam logic [15:0] ARS_RST_RESTRAIN = 16'h01F4;
    localparam logic [15:0] ARS_RST_CLOSE_MAX = 16'h0064;
    localparam logic [15:0] ARS_RST_ACTION = 16'h00C8;
    localparam logic [15:0] ARS_RST_HOLD_MAX = 16'h03E8;
    localparam logic [15:0] ARS_RST_LOCKOUT = 16'h01F4;
    // Sequencer states.
    typedef enum logic [5:0] {
        ARS_IDLE = 6'b000001,
        ARS_ACTIVE = 6'b000010,
        ARS_OPENWAIT = 6'b000100,
        ARS_DEAD = 6'b001000,
        ARS_RESTRAIN = 6'b010000,
        ARS_LOCKOUT = 6'b100000
    } ars_state_type;
endpackage
`default_nettype wire

// file: rtl/ars_sequencer.sv
// Auto-reclose sequencer with APB configuration and status registers.
//
// Contract
// R1: Ground program only when pickups show one phase, one phase plus ground, or ground.
// R2: Phase program in every other case, two or more phases picked up.
// R3: Each program can also be started by its own external start input.
// R4: Program choice uses latched pickup events only, collected until breaker opens.
// R5: Attempt count up to 9, set separately for each program.
// R6: Dead times for attempts one to four; later attempts reuse the fourth.
// R7: Dead time starts only after the breaker is seen open.
// R8: Dead time expiry raises close and starts restraint timer together.
// R9: New fault in restraint with no attempt left enters dynamic lockout.
// R10: Breaker open from auxiliary contact if configured, else pickup dropout.
// R11: Restraint expiry without fault returns the sequencer to idle.
// R12: Retrip in restraint with attempts left starts the next cycle.
// R13: Trip after last attempt gives no close and enters lockout.
// R14: Close held at most its maximum time; a trip withdraws it at once.
// R15: Restraint stretched while close command is still active.
// R16: A starter pickup during restraint restarts the restraint interval.
// R17: Program starts only on trip within action time; later trip locks out.
// R18: Hold input postpones dead time; held past its maximum locks out.
// R19: Lockout timer restarts while a blocking condition holds, else clears.
// R20: Attempt count clears on return to idle after success or lockout.
`timescale 1ns/1ns
`default_nettype none
module ars_sequencer
    import ars_pkg::*;
#(
    parameter int TICK_CYCLES = ARS_TICK_CYCLES
) (
    input wire logic mclk_in, // System clock, 100 MHz.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic psel_in, // APB select.
    input wire logic penable_in, // APB enable.
    input wire logic pwrite_in, // APB write.
    input wire logic [7:0] paddr_in, // APB byte address.
    input wire logic [31:0] pwdata_in, // APB write data.
    output logic [31:0] prdata_out, // APB read data.
    output logic pready_out, // APB ready.
    output logic pslverr_out, // APB error for unmapped address.
    input wire logic [2:0] phase_pickup_in, // Starter pickup per phase.
    input wire logic ground_pickup_in, // Starter ground pickup.
    input wire logic starter_trip_in, // Trip from a starter function.
    input wire logic ground_program_start_input, // External ground program start.
    input wire logic phase_program_start_input, // External phase program start.
    input wire logic dead_start_hold_input, // Postpones dead time start.
    input wire logic breaker_closed_aux_in, // Breaker auxiliary contact, high when closed.
    output logic close_cmd_out, // Breaker close command.
    output logic dynamic_lockout_flag // High during dynamic lockout.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw_in, sync_a, sync_b;
    assign raw_in = {breaker_closed_aux_in, dead_start_hold_input, phase_program_start_input,
                     ground_program_start_input, starter_trip_in, ground_pickup_in,
                     phase_pickup_in};
    // Two flip-flops per pin before any logic reads it.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    logic [2:0] pu_ph;
    logic pu_gnd, trip_s, start_gnd, start_ph, hold_s, cb_closed;
    assign pu_ph = sync_b[2:0];
    assign pu_gnd = sync_b[3];
    assign trip_s = sync_b[4];
    assign start_gnd = sync_b[5];
    assign start_ph = sync_b[6];
    assign hold_s = sync_b[7];
    assign cb_closed = sync_b[8];

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    logic aux_used, wr_en, rd_setup, mapped;
    logic [3:0] gnd_count, ph_count, gcnt_wr, pcnt_wr;
    logic [31:0] dead_gnd, dead_ph;
    logic [15:0] restrain_time, close_max, action_time, hold_max, lockout_time;
    assign wr_en = psel_in & penable_in & pwrite_in & mapped;
    assign rd_setup = psel_in & ~penable_in;
    assign mapped = (paddr_in <= ARS_OFF_STATUS) && (paddr_in[1:0] == 2'h0);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;
    assign gcnt_wr = pwdata_in[ARS_CTRL_GCNT_LSB +: 4];
    assign pcnt_wr = pwdata_in[ARS_CTRL_PCNT_LSB +: 4];
    // Register writes; attempt counts are clamped to the largest allowed.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            aux_used <= ARS_RST_AUX;
            gnd_count <= ARS_RST_GCNT;
            ph_count <= ARS_RST_PCNT;
            dead_gnd <= ARS_RST_DEAD;
            dead_ph <= ARS_RST_DEAD;
            restrain_time <= ARS_RST_RESTRAIN;
            close_max <= ARS_RST_CLOSE_MAX;
            action_time <= ARS_RST_ACTION;
            hold_max <= ARS_RST_HOLD_MAX;
            lockout_time <= ARS_RST_LOCKOUT;
        end else if (wr_en) begin
            case (paddr_in)
                ARS_OFF_CTRL: begin
                    aux_used <= pwdata_in[ARS_CTRL_AUX_BIT];
                    gnd_count <= (gcnt_wr > ARS_MAX_SHOTS) ? ARS_MAX_SHOTS : gcnt_wr; // [R5]
                    ph_count <= (pcnt_wr > ARS_MAX_SHOTS) ? ARS_MAX_SHOTS : pcnt_wr; // [R5]
                end
                ARS_OFF_DEAD_GND: dead_gnd <= pwdata_in;
                ARS_OFF_DEAD_PH: dead_ph <= pwdata_in;
                ARS_OFF_RESTRAIN: restrain_time <= pwdata_in[15:0];
                ARS_OFF_CLOSE_MAX: close_max <= pwdata_in[15:0];
                ARS_OFF_ACTION: action_time <= pwdata_in[15:0];
                ARS_OFF_HOLD_MAX: hold_max <= pwdata_in[15:0];
                ARS_OFF_LOCKOUT: lockout_time <= pwdata_in[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer tick, one pulse per tick period.
    logic [31:0] tick_cnt;
    logic tick;
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    // Free-running prescaler.
    always_ff @(posedge mclk_in) begin
        if (reset_in || tick) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    ars_state_type state;
    logic [15:0] tmr, ctmr;
    logic [3:0] shots, max_shots;
    logic [2:0] pat_ph;
    logic [1:0] dead_idx;
    logic [7:0] dead_sel;
    logic force_gnd, force_ph, prog_phase, pu_any, pu_prev;
    logic cb_open, multi_ph, sel_phase, tmr_zero;
    assign pu_any = (|pu_ph) | pu_gnd;
    assign cb_open = aux_used ? ~cb_closed : ~pu_any; // [R10]
    assign multi_ph = (pat_ph[0] & pat_ph[1]) | (pat_ph[0] & pat_ph[2]) | (pat_ph[1] & pat_ph[2]);
    assign sel_phase = force_ph | (~force_gnd & multi_ph); // [R1] [R2]
    assign max_shots = prog_phase ? ph_count : gnd_count;
    assign dead_idx = (shots > 4'h3) ? 2'h3 : shots[1:0]; // [R6]
    assign dead_sel = sel_phase ? dead_ph[dead_idx*8 +: 8] : dead_gnd[dead_idx*8 +: 8]; // [R6]
    assign tmr_zero = (tmr == 16'h0000);
    assign dynamic_lockout_flag = (state == ARS_LOCKOUT);
    // State, interval timer, attempt count and program choice.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state <= ARS_IDLE;
            tmr <= 16'h0000;
            shots <= 4'h0;
            pat_ph <= 3'h0;
            force_gnd <= 1'b0;
            force_ph <= 1'b0;
            prog_phase <= 1'b0;
            pu_prev <= 1'b0;
        end else begin
            pu_prev <= pu_any;
            if (tick && !tmr_zero) begin
                tmr <= tmr - 16'h0001;
            end
            case (state)
                ARS_IDLE: begin
                    pat_ph <= pu_ph;
                    force_gnd <= start_gnd & ~start_ph; // [R3]
                    force_ph <= start_ph; // [R3]
                    if (start_gnd || start_ph) begin
                        state <= ARS_OPENWAIT; // [R3]
                        tmr <= hold_max;
                    end else if (pu_any) begin
                        state <= ARS_ACTIVE;
                        tmr <= action_time; // [R17]
                    end
                end
                ARS_ACTIVE: begin
                    pat_ph <= pat_ph | pu_ph; // [R4]
                    if (trip_s && !tmr_zero) begin
                        state <= ARS_OPENWAIT; // [R17]
                        tmr <= hold_max;
                    end else if (trip_s) begin
                        state <= ARS_LOCKOUT; // [R17]
                        tmr <= lockout_time;
                    end else if (!pu_any) begin
                        state <= ARS_IDLE;
                    end
                end
                ARS_OPENWAIT: begin
                    if (!cb_open) begin
                        pat_ph <= pat_ph | pu_ph; // [R4]
                    end
                    if (shots >= (sel_phase ? ph_count : gnd_count)) begin
                        state <= ARS_LOCKOUT; // [R13]
                        tmr <= lockout_time;
                    end else if (hold_s && tmr_zero) begin
                        state <= ARS_LOCKOUT; // [R18]
                        tmr <= lockout_time;
                    end else if (cb_open && !hold_s) begin
                        state <= ARS_DEAD; // [R7] [R18]
                        prog_phase <= sel_phase;
                        tmr <= {8'h00, dead_sel}; // [R6]
                    end
                end
                ARS_DEAD: begin
                    // Dead time is loaded on entry, so an expired count is never reloaded.
                    if (tmr_zero && tick) begin
                        state <= ARS_RESTRAIN; // [R8]
                        tmr <= restrain_time; // [R8]
                        shots <= shots + 4'h1;
                    end
                end
                ARS_RESTRAIN: begin
                    if (trip_s && shots < max_shots) begin
                        state <= ARS_OPENWAIT; // [R12]
                        pat_ph <= pu_ph;
                        tmr <= hold_max;
                    end else if (trip_s) begin
                        state <= ARS_LOCKOUT; // [R9] [R13]
                        tmr <= lockout_time;
                    end else if (pu_any && !pu_prev) begin
                        tmr <= restrain_time; // [R16]
                    end else if (tmr_zero && !close_cmd_out) begin
                        state <= ARS_IDLE; // [R11] [R15]
                        shots <= 4'h0; // [R20]
                    end
                end
                ARS_LOCKOUT: begin
                    if (tmr_zero && (trip_s || pu_any || hold_s)) begin
                        tmr <= lockout_time; // [R19]
                    end else if (tmr_zero) begin
                        state <= ARS_IDLE; // [R19]
                        shots <= 4'h0; // [R20]
                    end
                end
                default: state <= ARS_IDLE;
            endcase
        end
    end
    // Close command with its own maximum-duration timer.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            close_cmd_out <= 1'b0;
            ctmr <= 16'h0000;
        end else if (state == ARS_DEAD && tmr_zero && tick) begin
            close_cmd_out <= 1'b1; // [R8]
            ctmr <= close_max;
        end else if (close_cmd_out && (trip_s || ctmr == 16'h0000)) begin
            close_cmd_out <= 1'b0; // [R14]
        end else if (tick && ctmr != 16'h0000) begin
            ctmr <= ctmr - 16'h0001; // [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read data, captured in the setup cycle.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr_in)
                ARS_OFF_CTRL: prdata_out <= {20'h0_0000, ph_count, gnd_count, 3'h0, aux_used};
                ARS_OFF_DEAD_GND: prdata_out <= dead_gnd;
                ARS_OFF_DEAD_PH: prdata_out <= dead_ph;
                ARS_OFF_RESTRAIN: prdata_out <= {16'h0000, restrain_time};
                ARS_OFF_CLOSE_MAX: prdata_out <= {16'h0000, close_max};
                ARS_OFF_ACTION: prdata_out <= {16'h0000, action_time};
                ARS_OFF_HOLD_MAX: prdata_out <= {16'h0000, hold_max};
                ARS_OFF_LOCKOUT: prdata_out <= {16'h0000, lockout_time};
                ARS_OFF_STATUS: prdata_out <= {17'h0_0000, dynamic_lockout_flag, close_cmd_out,
                                               prog_phase, shots, 2'h0, state};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_close_from_dead;
        $rose(close_cmd_out) |-> $past(state) == ARS_DEAD && state == ARS_RESTRAIN;
    endproperty
    a_close_from_dead: assert property (p_close_from_dead) else $error("close not from dead"); // [R8]
    property p_trip_drops_close;
        close_cmd_out && trip_s |=> !close_cmd_out;
    endproperty
    a_trip_drops_close: assert property (p_trip_drops_close) else $error("close kept on trip"); // [R14]
    property p_retrip_next;
        state == ARS_RESTRAIN && trip_s && shots < max_shots |=> state == ARS_OPENWAIT;
    endproperty
    a_retrip_next: assert property (p_retrip_next) else $error("retrip not recycled"); // [R12]
    property p_last_lock;
        state == ARS_RESTRAIN && trip_s && shots >= max_shots |=> state == ARS_LOCKOUT;
    endproperty
    a_last_lock: assert property (p_last_lock) else $error("final trip not locked"); // [R9]
    property p_no_close_lock;
        state == ARS_LOCKOUT |=> !$rose(close_cmd_out);
    endproperty
    a_no_close_lock: assert property (p_no_close_lock) else $error("close in lockout"); // [R13]
    property p_hold_blocks;
        state == ARS_OPENWAIT && hold_s |=> state != ARS_DEAD;
    endproperty
    a_hold_blocks: assert property (p_hold_blocks) else $error("dead time not held"); // [R18]
    property p_prog_phase;
        $rose(state == ARS_DEAD) && $past(multi_ph) && !$past(force_gnd) |-> prog_phase;
    endproperty
    a_prog_phase: assert property (p_prog_phase) else $error("wrong program"); // [R2]
    property p_idle_clears;
        $rose(state == ARS_IDLE) |-> shots == 4'h0;
    endproperty
    a_idle_clears: assert property (p_idle_clears) else $error("shots not cleared"); // [R20]
    property p_dead_needs_open;
        $rose(state == ARS_DEAD) |-> $past(cb_open);
    endproperty
    a_dead_needs_open: assert property (p_dead_needs_open) else $error("dead before open"); // [R7]
    c_reclose: cover property ($rose(close_cmd_out));
    c_success: cover property (state == ARS_RESTRAIN ##1 state == ARS_IDLE);
    c_lockout: cover property ($rose(state == ARS_LOCKOUT));
    c_second_shot: cover property ($rose(close_cmd_out) && shots == 4'h2);
endmodule
`default_nettype wire

// file: test/ars_breaker_model.sv
// Behavioural circuit breaker with an auxiliary contact.
`timescale 1ns/1ns
`default_nettype none
module ars_breaker_model #(
    parameter int MOVE_CYCLES = 3
) (
    input wire logic mclk_in, // System clock.
    input wire logic reset_in, // Synchronous reset, active high.
    input wire logic trip_in, // Trip command.
    input wire logic close_in, // Close command.
    output logic closed_out // Auxiliary contact, high when closed.
);
    int count;
    // Contacts move a fixed time after a command; a trip wins over a close.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            closed_out <= 1'h1;
            count <= 0;
        end else if ((trip_in && closed_out) || (close_in && !trip_in && !closed_out)) begin
            count <= count + 1;
            if (count == MOVE_CYCLES) begin
                closed_out <= !closed_out;
                count <= 0;
            end
        end else begin
            count <= 0;
        end
    end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the auto-reclose sequencer.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import ars_pkg::*;
;
    typedef struct packed {
        logic [2:0] ph;
        logic g;
        logic ps;
        logic gs;
        logic aux;
        logic exp;
    } ars_row_type;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] ph;
    logic g, trip, gs, ps, hold, aux, close, lock, e;
    int errors, total_checks, n;
    ars_row_type rows [7];
    ////////////////////////////////////////////////////////////////////////
    ars_sequencer #(.TICK_CYCLES(4)) dut (.mclk_in(mclk), .reset_in(reset),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .phase_pickup_in(ph), .ground_pickup_in(g),
        .starter_trip_in(trip), .ground_program_start_input(gs),
        .phase_program_start_input(ps), .dead_start_hold_input(hold),
        .breaker_closed_aux_in(aux), .close_cmd_out(close), .dynamic_lockout_flag(lock));
    ars_breaker_model partner (.mclk_in(mclk), .reset_in(reset), .trip_in(trip),
        .close_in(close), .closed_out(aux));
    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k >= 50) begin
            errors++;
            conclude();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    // Bounded wait for a level, sampled at the falling edge.
    task automatic wait_for(ref logic s, input logic v);
        int k;
        k = 0;
        total_checks++;
        do begin
            @(negedge mclk);
            k++;
        end while (s !== v && k < 400);
        if (k >= 400) begin
            errors++;
            $display("mismatch wait expected %b seen %b", v, s);
            conclude();
        end
        @(posedge mclk);
    endtask
    // Starter pickup and trip until the breaker opens.
    task automatic fault(input logic [2:0] p, input logic gp);
        ph <= p;
        g <= gp;
        trip <= 1'h1;
        repeat (6) @(negedge mclk);
        check("close on trip", {31'h0, close}, 32'h0000_0000);
        wait_for(aux, 1'h0);
        ph <= 3'h0;
        g <= 1'h0;
        trip <= 1'h0;
    endtask
    // Polls status until idle.
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'h0, ARS_OFF_STATUS, 32'h0000_0000);
            k++;
        end while (q[5:0] !== 6'h01 && k < 100);
        check("idle and shots", {20'h0, q[11:0]}, 32'h0000_0001);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Free-running system clock.
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // Main sequence.
    initial begin
        reset = 1'h1;
        {psel, penable, pwrite, ph, g, trip, gs, ps, hold} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        errors = 0;
        total_checks = 0;
        rows = '{'{3'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0}, '{3'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
            '{3'h2, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0}, '{3'h3, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1},
            '{3'h5, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1}, '{3'h4, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
            '{3'h3, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0}};
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        check("lockout after reset", {31'h0, lock}, 32'h0000_0000);
        apb(1'h0, ARS_OFF_STATUS, 32'h0000_0000);
        check("status reset", q, 32'h0000_0001);
        apb(1'h0, ARS_OFF_CTRL, 32'h0000_0000);
        check("control reset", q, 32'h0000_0111);
        apb(1'h0, 8'h24, 32'h0000_0000);
        check("unmapped error", {31'h0, e}, 32'h0000_0001);
        apb(1'h1, ARS_OFF_DEAD_GND, 32'h0403_0201);
        apb(1'h1, ARS_OFF_DEAD_PH, 32'h0201_0403);
        apb(1'h1, ARS_OFF_RESTRAIN, 32'h0000_0004);
        apb(1'h1, ARS_OFF_CLOSE_MAX, 32'h0000_0005);
        apb(1'h1, ARS_OFF_ACTION, 32'h0000_0003);
        apb(1'h1, ARS_OFF_HOLD_MAX, 32'h0000_0003);
        apb(1'h1, ARS_OFF_LOCKOUT, 32'h0000_0003);
        $display("test reset and setup done");
        foreach (rows[i]) begin
            apb(1'h1, ARS_OFF_CTRL, 32'h0000_0110 | {31'h0, rows[i].aux});
            gs <= rows[i].gs;
            ps <= rows[i].ps;
            fault(rows[i].ph, rows[i].g);
            wait_for(close, 1'h1);
            apb(1'h0, ARS_OFF_STATUS, 32'h0000_0000);
            check("program", {31'h0, q[12]}, {31'h0, rows[i].exp});
            check("close status", {31'h0, q[13]}, 32'h0000_0001);
            gs <= 1'h0;
            ps <= 1'h0;
            wait_for(close, 1'h0);
            wait_idle();
        end
        $display("test program table done");
        apb(1'h1, ARS_OFF_CTRL, 32'h0000_0311);
        fault(3'h7, 1'h0);
        for (int k = 1; k <= 3; k++) begin
            wait_for(close, 1'h1);
            apb(1'h0, ARS_OFF_STATUS, 32'h0000_0000);
            check("shots", {28'h0, q[11:8]}, k);
            wait_for(aux, 1'h1);
            fault(3'h7, 1'h0);
        end
        wait_for(lock, 1'h1);
        n = 0;
        repeat (40) begin
            @(negedge mclk);
            n += int'(close);
        end
        @(posedge mclk);
        check("close after final trip", n, 32'h0000_0000);
        wait_for(lock, 1'h0);
        wait_idle();
        $display("test multi shot done");
        apb(1'h1, ARS_OFF_CTRL, 32'h0000_0111);
        ph <= 3'h1;
        repeat (30) @(posedge mclk);
        trip <= 1'h1;
        wait_for(lock, 1'h1);
        ph <= 3'h0;
        trip <= 1'h0;
        wait_for(lock, 1'h0);
        $display("test action time done");
        hold <= 1'h1;
        fault(3'h1, 1'h0);
        wait_for(lock, 1'h1);
        repeat (30) @(negedge mclk);
        check("lockout held", {31'h0, lock}, 32'h0000_0001);
        @(posedge mclk);
        hold <= 1'h0;
        wait_for(lock, 1'h0);
        $display("test dead start hold done");
        apb(1'h1, ARS_OFF_CTRL, 32'h0000_0320);
        reset <= 1'h1;
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        check("lockout after second reset", {31'h0, lock}, 32'h0000_0000);
        apb(1'h0, ARS_OFF_CTRL, 32'h0000_0000);
        check("control after second reset", q, 32'h0000_0111);
        apb(1'h0, ARS_OFF_DEAD_GND, 32'h0000_0000);
        check("dead time after second reset", q, ARS_RST_DEAD);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
`default_nettype wire
